// [bench/sfcr_host_model.sv]
// host side model that drives serial link frames into the register block
`default_nettype none
module sfcr_host_model (
  input  wire logic clk_in,   // system clock
  input  wire logic so_in,    // serial data from device
  output var  logic sck_out,  // serial clock, low outside frames
  output var  logic cs_n_out, // chip select, low active
  output var  logic si_out    // serial data to device
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    sck_out = 1'b0;
    cs_n_out = 1'b1;
    si_out = 1'b0;
  end
  // data line is flipped at select changes so a stale bit is never mistaken for a held one
  task automatic sel(input logic v);
    @(negedge clk_in);
    cs_n_out = v;
    si_out = ~si_out;
    repeat (4) @(negedge clk_in);
  endtask : sel
  // one 800 ns sck period; so is taken at the end of the high half, well after it settled
  task automatic cyc(input logic b, output logic r);
    si_out = b;
    repeat (4) @(negedge clk_in);
    sck_out = 1'b1;
    repeat (4) @(negedge clk_in);
    r = so_in;
    sck_out = 1'b0;
  endtask : cyc
  // opcode msb first, then exactly nw write bits
  task automatic xfer(input logic [7:0] op, input int nw, input logic [31:0] wd, input int nr,
                      output logic [31:0] rd);
    logic b;
    rd = 32'h0;
    sel(1'b0);
    for (int i = 7; i >= 0; i--) cyc(op[i], b);
    for (int i = nw - 1; i >= 0; i--) cyc(wd[i], b);
    for (int i = 0; i < nr; i++) begin
      cyc(1'b0, b);
      rd = {rd[30:0], b};
    end
    sel(1'b1);
  endtask : xfer
endmodule : sfcr_host_model
`default_nettype wire

// [bench/sfcr_top_tb.sv]
// self-checking bench of the serial flash configuration registers
`default_nettype none
module sfcr_top_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk = 1'b0, srst = 1'b1, swr = 1'b0, finit = 1'b1, dl3 = 1'b1, quad = 1'b0;
  logic es = 1'b1, ps = 1'b0, bd = 1'b0, b, sck, cs_n, si, so, oe, ess, hyb, pws, l3f, pau, l3r, aws, bact, so_bus;
  logic [17:0] ebm;
  logic [8:0]  pwm;
  logic [7:0]  upa;
  logic [31:0] bad, rd;
  int          bad_count = 0, compares = 0;
  always #50 clk = ~clk;
  sfcr_top u_sfcr_top (.core_clk_in(clk), .srst_in(srst), .sw_reset_in(swr), .factory_init_in(finit),
    .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .data_line_3_in(dl3), .quad_mode_in(quad),
    .erase_suspended_in(es), .program_suspended_in(ps), .boot_data_in(bd), .so_out(so), .so_oe_out(oe),
    .erase_size_select_out(ess), .hybrid_layout_out(hyb), .erase_block_mask_out(ebm),
    .page_wrap_select_out(pws), .page_wrap_mask_out(pwm), .line3_function_select_out(l3f),
    .pause_active_out(pau), .dl3_reset_out(l3r), .address_width_select_out(aws), .upper_addr_out(upa),
    .boot_active_out(bact), .boot_addr_out(bad));
  // released data line floats to its pull-up level
  assign so_bus = oe ? so : 1'b1;
  sfcr_host_model u_sfcr_host_model (.clk_in(clk), .so_in(so_bus), .sck_out(sck), .cs_n_out(cs_n), .si_out(si));
  // ****************************************
  // shared tasks
  // ****************************************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      bad_count++;
    end
  endtask : chk
  task automatic conclude();
    $display("compares=%0d bad_count=%0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : conclude
  task automatic w(input int n);
    repeat (n) @(negedge clk);
  endtask : w
  task automatic wr(input logic [7:0] op, input int n, input logic [31:0] d);
    u_sfcr_host_model.xfer(op, n, d, 0, rd);
  endtask : wr
  task automatic rdr(input logic [7:0] op, input int n, input logic [31:0] exp);
    u_sfcr_host_model.xfer(op, 0, 32'h0, n, rd);
    chk(rd, exp);
  endtask : rdr
  task automatic swp();
    swr = 1'b1;
    w(1);
    swr = 1'b0;
    w(6);
  endtask : swp
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    w(5);
    srst = 1'b0;
    finit = 1'b0;
    w(10);
    chk(ebm, 18'h0ffff);
    chk(pwm, 9'h0ff);
    chk(hyb, 1'b1);
    u_sfcr_host_model.sel(1'b0);
    dl3 = 1'b0;
    w(6);
    chk(pau, 1'b1);
    quad = 1'b1;
    w(4);
    chk(pau, 1'b0);
    quad = 1'b0;
    dl3 = 1'b1;
    u_sfcr_host_model.sel(1'b1);
    rdr(8'h07, 8, 32'h02);
    wr(8'h01, 24, 32'hff);
    es = 1'b0;
    ps = 1'b1;
    rdr(8'h07, 8, 32'he1);
    chk({ess, ebm}, 19'h7ffff);
    chk({pws, pwm}, 10'h3ff);
    wr(8'h01, 24, 32'h0);
    w(3);
    srst = 1'b1;
    w(5);
    srst = 1'b0;
    w(10);
    rdr(8'h07, 8, 32'he1);
    chk(l3f, 1'b1);
    quad = 1'b1;
    u_sfcr_host_model.sel(1'b0);
    dl3 = 1'b0;
    w(6);
    chk(l3r, 1'b0);
    quad = 1'b0;
    w(6);
    chk(l3r, 1'b1);
    dl3 = 1'b1;
    u_sfcr_host_model.sel(1'b1);
    w(6);
    wr(8'h15, 32, 32'h2205);
    rdr(8'h14, 32, 32'h2205);
    chk(bad, 32'h2200);
    swp();
    bd = 1'b1;
    u_sfcr_host_model.sel(1'b0);
    u_sfcr_host_model.cyc(1'b0, b);
    chk(bact, 1'b0);
    u_sfcr_host_model.cyc(1'b0, b);
    u_sfcr_host_model.cyc(1'b0, b);
    w(6);
    chk({bact, oe, so}, 3'h7);
    u_sfcr_host_model.sel(1'b1);
    wr(8'h15, 32, 32'h0);
    wr(8'h17, 8, 32'h83);
    rdr(8'h16, 8, 32'h80);
    chk({aws, upa}, 9'h100);
    swp();
    chk({aws, upa}, 9'h000);
    wr(8'hb9, 0, 32'h0);
    wr(8'h01, 8, 32'h80);
    w(3);
    chk(aws, 1'b1);
    conclude();
  end
  // the whole sequence needs well under 10000 clocks
  initial begin
    repeat (40000) @(posedge clk);
    bad_count++;
    conclude();
  end
endmodule : sfcr_top_tb
`default_nettype wire

// [rtl/sfcr_defines.svh]
// constants of the serial flash configuration register block
`ifndef SFCR_DEFINES_SVH
`define SFCR_DEFINES_SVH

`define SFCR_REGISTER_WRITE_CMD      8'h01
`define SFCR_SECOND_STATUS_READ_CMD  8'h07
`define SFCR_BOOT_CONFIG_READ_CMD    8'h14
`define SFCR_BOOT_CONFIG_WRITE_CMD   8'h15
`define SFCR_BANK_READ_CMD           8'h16
`define SFCR_BANK_WRITE_CMD          8'h17
`define SFCR_BANK_ACCESS_CMD         8'hb9

`define SFCR_OTP_WRITE_BITS          8'h18
`define SFCR_BOOT_WRITE_BITS         8'h20
`define SFCR_BYTE_BITS               8'h08
`define SFCR_OPCODE_LAST             8'h07
`define SFCR_COUNT_MAX               8'hff

`define SFCR_OTP_MSB                 7
`define SFCR_OTP_LSB                 5
`define SFCR_OTP_ERASE_IDX           2
`define SFCR_OTP_WRAP_IDX            1
`define SFCR_OTP_LINE3_IDX           0
`define SFCR_OTP_RESET               3'h0
`define SFCR_STAT2_RSVD              3'h0
`define SFCR_ADDR_WIDTH_BIT          7
`define SFCR_BANK_RSVD               7'h00
`define SFCR_BANK_BITS_RESET         2'h0
`define SFCR_UPPER_PAD               6'h00
`define SFCR_READ_PAD                24'h000000

`define SFCR_BOOT_RESET              32'h00000000
`define SFCR_BOOT_EN_BIT             0
`define SFCR_BOOT_DLY_MSB            8
`define SFCR_BOOT_DLY_LSB            1
`define SFCR_BOOT_ADDR_MSB           31
`define SFCR_BOOT_ADDR_LSB           9
`define SFCR_BOOT_ADDR_PAD           9'h000

`define SFCR_WRAP_512_MASK           9'h1ff
`define SFCR_WRAP_256_MASK           9'h0ff
`define SFCR_ERASE_256K_MASK         18'h3ffff
`define SFCR_ERASE_64K_MASK          18'h0ffff

`define SFCR_PIN_SCK                 0
`define SFCR_PIN_CS                  1
`define SFCR_PIN_SI                  2
`define SFCR_PIN_DL3                 3
`define SFCR_PIN_COUNT               4
`define SFCR_PIN_IDLE                4'ha

`endif

// [rtl/sfcr_nv_if.sv]
// carrier between the frame logic and the nonvolatile store
`default_nettype none
interface sfcr_nv_if;
  logic        wr_otp;
  logic        wr_boot;
  logic [2:0]  otp_wdata;
  logic [31:0] boot_wdata;
  logic [2:0]  otp_q;
  logic [31:0] boot_q;
  modport ctrl  (output wr_otp, output wr_boot, output otp_wdata, output boot_wdata,
                 input otp_q, input boot_q);
  modport store (input wr_otp, input wr_boot, input otp_wdata, input boot_wdata,
                 output otp_q, output boot_q);
endinterface : sfcr_nv_if
`default_nettype wire

// [rtl/sfcr_nv_store.sv]
// nonvolatile cells: otp option bits and boot read word
`include "sfcr_defines.svh"
`default_nettype none
module sfcr_nv_store
  import sfcr_pkg::*;
(
  input  wire logic core_clk_in,     // system clock
  input  wire logic factory_init_in, // blank the cells, manufacturing only
  sfcr_nv_if.store  nv               // write strobes and stored words
);
  // no srst here: cells keep their contents through every reset
  always_ff @(posedge core_clk_in) begin
    if (factory_init_in) begin
      nv.otp_q  <= `SFCR_OTP_RESET;
      nv.boot_q <= `SFCR_BOOT_RESET;
    end else begin
      if (nv.wr_otp) begin
        nv.otp_q <= nv.otp_q | nv.otp_wdata;
      end
      if (nv.wr_boot) begin
        nv.boot_q <= nv.boot_wdata;
      end
    end
  end

  a_otp_never_clears : assert property (@(posedge core_clk_in) disable iff (factory_init_in)
    ($past(nv.otp_q) & ~nv.otp_q) == 3'h0)
    else $error("otp option bit returned to zero");
endmodule : sfcr_nv_store
`default_nettype wire

// [rtl/sfcr_pkg.sv]
// types of the serial flash configuration register block
`default_nettype none
package sfcr_pkg;
  typedef enum logic [2:0] {
    ST_OPCODE,
    ST_WRITE_IN,
    ST_READ_OUT,
    ST_BOOT_WAIT,
    ST_BOOT_OUT,
    ST_SKIP
  } sfcr_state_t;
endpackage : sfcr_pkg
`default_nettype wire

// [rtl/sfcr_top.sv]
// serial flash configuration registers: serial frame decode, options, boot read
`include "sfcr_defines.svh"
`default_nettype none
module sfcr_top
  import sfcr_pkg::*;
(
  input  wire logic        core_clk_in,               // 10 MHz system clock
  input  wire logic        srst_in,                   // power-on reset, sync, high
  input  wire logic        sw_reset_in,               // software reset pulse
  input  wire logic        factory_init_in,           // blank nonvolatile cells
  input  wire logic        sck_in,                    // serial clock pin
  input  wire logic        cs_n_in,                   // chip select pin, low active
  input  wire logic        si_in,                     // serial data in pin
  input  wire logic        data_line_3_in,            // data_line_3 pin level
  input  wire logic        quad_mode_in,              // quad width option bit
  input  wire logic        erase_suspended_in,        // erase engine suspended
  input  wire logic        program_suspended_in,      // program engine suspended
  input  wire logic        boot_data_in,              // array bit for boot stream
  output logic             so_out,                    // serial data out
  output logic             so_oe_out,                 // serial data out enable
  output logic             erase_size_select_out,     // 1: 256 KB uniform erase
  output logic             hybrid_layout_out,         // small sectors present
  output logic [17:0]      erase_block_mask_out,      // offset mask of D8h block
  output logic             page_wrap_select_out,      // 1: 512 byte wrap
  output logic [8:0]       page_wrap_mask_out,        // buffer load address mask
  output logic             line3_function_select_out, // 1: reset function in force
  output logic             pause_active_out,          // pause asserted on line 3
  output logic             dl3_reset_out,             // reset asserted on line 3
  output logic             address_width_select_out,  // 1: four byte addresses
  output logic [7:0]       upper_addr_out,            // address bits above A23
  output logic             boot_active_out,           // boot stream on so_out
  output logic [31:0]      boot_addr_out              // boot start byte address
);
  // ****************************************************************
  // pin synchronisers
  // ****************************************************************
  logic [`SFCR_PIN_COUNT-1:0] pin_w;
  logic [`SFCR_PIN_COUNT-1:0] s1_r;
  logic [`SFCR_PIN_COUNT-1:0] s2_r;
  logic [`SFCR_PIN_COUNT-1:0] s3_r;
  logic [`SFCR_PIN_COUNT-1:0] filt_r;
  logic [`SFCR_PIN_COUNT-1:0] prev_r;

  assign pin_w[`SFCR_PIN_SCK] = sck_in;
  assign pin_w[`SFCR_PIN_CS]  = cs_n_in;
  assign pin_w[`SFCR_PIN_SI]  = si_in;
  assign pin_w[`SFCR_PIN_DL3] = data_line_3_in;

  // stages start at each pin's idle level, so leaving reset shows no false edge
  localparam logic [`SFCR_PIN_COUNT-1:0] pin_idle = `SFCR_PIN_IDLE;

  // a change counts only once stages two and three agree
  for (genvar g = 0; g < `SFCR_PIN_COUNT; g++) begin : g_sync
    always_ff @(posedge core_clk_in) begin
      if (srst_in) begin
        s1_r[g]   <= pin_idle[g];
        s2_r[g]   <= pin_idle[g];
        s3_r[g]   <= pin_idle[g];
        filt_r[g] <= pin_idle[g];
        prev_r[g] <= pin_idle[g];
      end else begin
        s1_r[g]   <= pin_w[g];
        s2_r[g]   <= s1_r[g];
        s3_r[g]   <= s2_r[g];
        prev_r[g] <= filt_r[g];
        if (s2_r[g] == s3_r[g]) begin
          filt_r[g] <= s3_r[g];
        end
      end
    end
  end

  // ****************************************************************
  // state and decode
  // ****************************************************************
  sfcr_nv_if    nv ();
  sfcr_state_t  state_r;
  logic [7:0]   op_r;
  logic [7:0]   cnt_r;
  logic [31:0]  in_sh_r;
  logic [31:0]  out_sh_r;
  logic         so_r;
  logic         so_oe_r;
  logic         bank_acc_r;
  logic         addr_width_r;
  logic         l3_mode_r;
  logic         boot_pending_r;

  logic         cs_low_w;
  logic         cs_fall_w;
  logic         cs_rise_w;
  logic         pause_w;
  logic         dl3_busy_w;
  logic         dl3_rst_w;
  logic         rst_all_w;
  logic         act_rise_w;
  logic         act_fall_w;
  logic [7:0]   op_byte_w;
  logic         op_done_w;
  logic [7:0]   sr2_rd_w;
  logic [7:0]   bank_rd_w;
  logic [1:0]   bank_bits_w;
  logic [7:0]   boot_dly_w;
  logic         commit_w;
  logic         bank_wr_w;
  logic         stat_load_w;

  function automatic sfcr_state_t sfcr_next_state(input logic [7:0] op);
    unique case (op)
      `SFCR_REGISTER_WRITE_CMD,
      `SFCR_BOOT_CONFIG_WRITE_CMD,
      `SFCR_BANK_WRITE_CMD:         sfcr_next_state = ST_WRITE_IN;
      `SFCR_SECOND_STATUS_READ_CMD,
      `SFCR_BOOT_CONFIG_READ_CMD,
      `SFCR_BANK_READ_CMD:          sfcr_next_state = ST_READ_OUT;
      default:                      sfcr_next_state = ST_SKIP;
    endcase
  endfunction : sfcr_next_state

  function automatic logic [31:0] sfcr_read_word(input logic [7:0] op, input logic [7:0] stat2,
                                                 input logic [31:0] boot, input logic [7:0] bank);
    unique case (op)
      `SFCR_SECOND_STATUS_READ_CMD: sfcr_read_word = {stat2, `SFCR_READ_PAD};
      `SFCR_BOOT_CONFIG_READ_CMD:   sfcr_read_word = boot;
      `SFCR_BANK_READ_CMD:          sfcr_read_word = {bank, `SFCR_READ_PAD};
      default:                      sfcr_read_word = `SFCR_BOOT_RESET;
    endcase
  endfunction : sfcr_read_word

  assign cs_low_w   = ~filt_r[`SFCR_PIN_CS];
  assign cs_fall_w  = ~filt_r[`SFCR_PIN_CS] & prev_r[`SFCR_PIN_CS];
  assign cs_rise_w  = filt_r[`SFCR_PIN_CS] & ~prev_r[`SFCR_PIN_CS];
  assign dl3_busy_w = quad_mode_in & cs_low_w;
  assign dl3_rst_w  = l3_mode_r & ~dl3_busy_w & ~filt_r[`SFCR_PIN_DL3];
  assign pause_w    = ~l3_mode_r & ~quad_mode_in & cs_low_w & ~filt_r[`SFCR_PIN_DL3];
  assign rst_all_w  = srst_in | sw_reset_in | dl3_rst_w;
  // pause freezes the shifter but keeps the frame alive
  assign act_rise_w = cs_low_w & ~pause_w & filt_r[`SFCR_PIN_SCK] & ~prev_r[`SFCR_PIN_SCK];
  assign act_fall_w = cs_low_w & ~pause_w & ~filt_r[`SFCR_PIN_SCK] & prev_r[`SFCR_PIN_SCK];
  assign op_byte_w  = {op_r[6:0], filt_r[`SFCR_PIN_SI]};
  assign op_done_w  = act_rise_w && state_r == ST_OPCODE && cnt_r == `SFCR_OPCODE_LAST;

  assign sr2_rd_w    = {nv.otp_q, `SFCR_STAT2_RSVD, erase_suspended_in, program_suspended_in};
  assign bank_bits_w = `SFCR_BANK_BITS_RESET;
  assign bank_rd_w   = {addr_width_r, `SFCR_BANK_RSVD};
  assign boot_dly_w  = nv.boot_q[`SFCR_BOOT_DLY_MSB:`SFCR_BOOT_DLY_LSB];

  // ****************************************************************
  // write commit at chip select rise
  // ****************************************************************
  assign commit_w = cs_rise_w & ~rst_all_w & (state_r == ST_WRITE_IN);
  assign bank_wr_w = commit_w && cnt_r == `SFCR_BYTE_BITS &&
                     (op_r == `SFCR_BANK_WRITE_CMD || (op_r == `SFCR_REGISTER_WRITE_CMD && bank_acc_r));
  // otp change needs exactly 24 bits
  assign nv.wr_otp     = commit_w && op_r == `SFCR_REGISTER_WRITE_CMD && !bank_acc_r &&
                         cnt_r == `SFCR_OTP_WRITE_BITS;
  assign nv.otp_wdata  = in_sh_r[`SFCR_OTP_MSB:`SFCR_OTP_LSB];
  assign nv.wr_boot    = commit_w && op_r == `SFCR_BOOT_CONFIG_WRITE_CMD && cnt_r == `SFCR_BOOT_WRITE_BITS;
  assign nv.boot_wdata = in_sh_r;

  sfcr_nv_store u_store (
    .core_clk_in     (core_clk_in),
    .factory_init_in (factory_init_in),
    .nv              (nv.store)
  );

  // ****************************************************************
  // frame engine
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_all_w || !cs_low_w) begin
      state_r <= ST_OPCODE;
      cnt_r   <= '0;
    end else if (cs_fall_w && boot_pending_r) begin
      state_r <= (boot_dly_w == '0) ? ST_BOOT_OUT : ST_BOOT_WAIT;
      cnt_r   <= '0;
    end else if (op_done_w) begin
      op_r     <= op_byte_w;
      state_r  <= sfcr_next_state(op_byte_w);
      out_sh_r <= sfcr_read_word(op_byte_w, sr2_rd_w, nv.boot_q, bank_rd_w);
      cnt_r    <= '0;
    end else if (act_rise_w) begin
      unique case (state_r)
        ST_OPCODE: begin
          op_r  <= op_byte_w;
          cnt_r <= cnt_r + 8'h01;
        end
        ST_WRITE_IN: begin
          in_sh_r <= {in_sh_r[30:0], filt_r[`SFCR_PIN_SI]};
          if (cnt_r != `SFCR_COUNT_MAX) begin
            cnt_r <= cnt_r + 8'h01;
          end
        end
        ST_BOOT_WAIT: begin
          cnt_r <= cnt_r + 8'h01;
          if (cnt_r + 8'h01 == boot_dly_w) begin
            state_r <= ST_BOOT_OUT;
          end
        end
        ST_READ_OUT, ST_BOOT_OUT, ST_SKIP: begin
        end
      endcase
    end else if (act_fall_w && state_r == ST_READ_OUT) begin
      out_sh_r <= {out_sh_r[30:0], 1'b0};
    end
  end

  // data out changes on the falling edge, host samples at the end of the following high half
  always_ff @(posedge core_clk_in) begin
    if (rst_all_w || !cs_low_w) begin
      so_r    <= 1'b0;
      so_oe_r <= 1'b0;
    end else if (act_fall_w && state_r == ST_READ_OUT) begin
      so_r    <= out_sh_r[31];
      so_oe_r <= 1'b1;
    end else if (act_fall_w && state_r == ST_BOOT_OUT) begin
      so_r    <= boot_data_in;
      so_oe_r <= 1'b1;
    end
  end

  // ****************************************************************
  // volatile control
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (rst_all_w) begin
      addr_width_r <= 1'b0;
      bank_acc_r   <= 1'b0;
    end else if (bank_wr_w) begin
      addr_width_r <= in_sh_r[`SFCR_ADDR_WIDTH_BIT];
      bank_acc_r   <= 1'b0;
    end else if (op_done_w) begin
      bank_acc_r <= (op_byte_w == `SFCR_BANK_ACCESS_CMD) |
                    (op_byte_w == `SFCR_REGISTER_WRITE_CMD & bank_acc_r);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_all_w) begin
      l3_mode_r      <= nv.otp_q[`SFCR_OTP_LINE3_IDX];
      boot_pending_r <= nv.boot_q[`SFCR_BOOT_EN_BIT];
    end else if (cs_rise_w && boot_pending_r) begin
      boot_pending_r <= 1'b0;
    end
  end

  // ****************************************************************
  // registered outputs
  // ****************************************************************
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      erase_size_select_out     <= 1'b0;
      hybrid_layout_out         <= 1'b1;
      erase_block_mask_out      <= `SFCR_ERASE_64K_MASK;
      page_wrap_select_out      <= 1'b0;
      page_wrap_mask_out        <= `SFCR_WRAP_256_MASK;
      line3_function_select_out <= 1'b0;
      pause_active_out          <= 1'b0;
      dl3_reset_out             <= 1'b0;
      address_width_select_out  <= 1'b0;
      upper_addr_out            <= '0;
      boot_active_out           <= 1'b0;
      boot_addr_out             <= `SFCR_BOOT_RESET;
    end else begin
      erase_size_select_out     <= nv.otp_q[`SFCR_OTP_ERASE_IDX];
      hybrid_layout_out         <= ~nv.otp_q[`SFCR_OTP_ERASE_IDX];
      erase_block_mask_out      <= nv.otp_q[`SFCR_OTP_ERASE_IDX] ? `SFCR_ERASE_256K_MASK : `SFCR_ERASE_64K_MASK;
      page_wrap_select_out      <= nv.otp_q[`SFCR_OTP_WRAP_IDX];
      page_wrap_mask_out        <= nv.otp_q[`SFCR_OTP_WRAP_IDX] ? `SFCR_WRAP_512_MASK : `SFCR_WRAP_256_MASK;
      line3_function_select_out <= l3_mode_r;
      pause_active_out          <= pause_w;
      dl3_reset_out             <= dl3_rst_w;
      address_width_select_out  <= addr_width_r;
      // bank bits only in 3-byte mode
      upper_addr_out            <= addr_width_r ? '0 : {`SFCR_UPPER_PAD, bank_bits_w};
      boot_active_out           <= (state_r == ST_BOOT_OUT);
      boot_addr_out             <= {nv.boot_q[`SFCR_BOOT_ADDR_MSB:`SFCR_BOOT_ADDR_LSB], `SFCR_BOOT_ADDR_PAD};
    end
  end

  assign so_out    = so_r;
  assign so_oe_out = so_oe_r;

  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  // status word as it lands in the read shifter
  assign stat_load_w = op_done_w && !rst_all_w && !cs_fall_w &&
                       op_byte_w == `SFCR_SECOND_STATUS_READ_CMD;

  a_reserved_stat2 : assert property (stat_load_w |=> out_sh_r[28:26] == 3'h0)
    else $error("reserved status bits not zero");
  a_erase_suspend_flag : assert property (stat_load_w |=> out_sh_r[25] == $past(erase_suspended_in))
    else $error("erase suspend flag does not follow engine");
  a_program_suspend_flag : assert property (stat_load_w |=> out_sh_r[24] == $past(program_suspended_in))
    else $error("program suspend flag does not follow engine");
  a_wrap_point : assert property (1 |=> page_wrap_mask_out ==
    ($past(nv.otp_q[1]) ? 9'h1ff : 9'h0ff))
    else $error("page wrap mask wrong");
  a_erase_span : assert property (1 |=> erase_block_mask_out ==
    ($past(nv.otp_q[2]) ? 18'h3ffff : 18'h0ffff) && hybrid_layout_out == !$past(nv.otp_q[2]))
    else $error("erase block span wrong");
  a_width_cleared : assert property (rst_all_w |=> !addr_width_r ##1 !address_width_select_out)
    else $error("address width not cleared by reset");
  a_bank_ignored : assert property (addr_width_r |=> upper_addr_out == 8'h00)
    else $error("bank bits used in four byte mode");
  a_boot_armed : assert property (rst_all_w |=> boot_pending_r == $past(nv.boot_q[0]))
    else $error("boot read armed against enable bit");
  a_dl3_reset_gate : assert property (quad_mode_in && cs_low_w |=> !dl3_reset_out)
    else $error("line 3 reset taken while line carries data");
  a_pause_quad : assert property (quad_mode_in |=> !pause_active_out)
    else $error("pause seen in quad mode");
  a_otp_write_len : assert property (nv.wr_otp |=> (nv.otp_q & $past(nv.otp_wdata)) == $past(nv.otp_wdata))
    else $error("otp write with 24 data bits did not land");
  a_boot_entry : assert property (cs_fall_w && boot_pending_r && !rst_all_w |=>
    state_r inside {ST_BOOT_WAIT, ST_BOOT_OUT})
    else $error("armed boot read not started at select");

  c_boot_stream : cover property ($rose(boot_active_out));
  c_otp_write : cover property (nv.wr_otp);
  c_bank_write : cover property (bank_wr_w ##1 addr_width_r);
  c_status_read : cover property (op_done_w && op_byte_w == 8'h07);
  c_line3_reset : cover property (dl3_reset_out);
endmodule : sfcr_top
`default_nettype wire
